// [logic/osc_pkg.sv]
/*
 * Shared constants for the output stage control register bank.
 * Assumes a 32-bit APB slave with word-aligned register indices.
 */
package osc_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    // Printed offsets are word indices; byte address is four times
    localparam logic [9:0] IDX_GAINS = 10'h03f;
    localparam logic [9:0] IDX_LINK = 10'h040;
    localparam logic [9:0] IDX_FREQ = 10'h041;
    localparam logic [9:0] IDX_OGAIN = 10'h042;
    localparam logic [9:0] IDX_SAT = 10'h043;
    localparam logic [9:0] IDX_PMCFG = 10'h044;
    localparam logic [9:0] IDX_TLOW = 10'h045;
    localparam logic [9:0] IDX_THIGH = 10'h046;
    localparam logic [9:0] IDX_TAPS = 10'h047;
    localparam logic [9:0] IDX_MASK = 10'h048;
    localparam int LOWER_LSB = 16;
    localparam int UPPER_LSB = 0;
    localparam logic [7:0] LOWER_RST = 8'h80;
    localparam logic [11:0] UPPER_RST = 12'h800;
    localparam int ALT_BIT = 13;
    localparam int SPARE_LSB = 8;
    localparam int AC_OFF_BIT = 6;
    localparam int BD_OFF_BIT = 5;
    localparam int COMPL_BIT = 4;
    localparam int PCLK_EN_BIT = 3;
    localparam int XOR_EN_BIT = 2;
    localparam int SYNC_EN_BIT = 1;
    localparam int LOAD_BIT = 0;
    localparam logic [9:0] LINK_RST = 10'h002;
    localparam int FREQ_W = 22;
    localparam int GAIN_W = 9;
    localparam int SIXTH_LSB = 16;
    localparam int FIFTH_LSB = 0;
    localparam logic [8:0] SIXTH_RST = 9'h100;
    localparam logic [8:0] FIFTH_RST = 9'h000;
    localparam int CNT_W = 12;
    localparam int P6_LSB = 16;
    localparam int P5_LSB = 0;
    localparam int SAT_N = 6;
    localparam int SAT_POS[SAT_N] = '{31, 30, 29, 28, 13, 12};
    localparam int THR_LSB = 8;
    localparam int COLLECT_BIT = 2;
    localparam int ABOVE_BIT = 1;
    localparam int CRST_BIT = 0;
    localparam int TIMER_W = 48;
    localparam int TAP_W = 16;
    localparam int XOR_TAP_LSB = 16;
    localparam logic [15:0] XOR_TAP_RST = 16'h0500;
    localparam logic [15:0] SYNC_TAP_RST = 16'hb400;
    localparam logic [15:0] LFSR_SEED = 16'hffff;
    typedef enum logic [2:0]
    {
        OSC_IDLE = 3'b001,
        OSC_SETUP = 3'b010,
        OSC_ACCESS = 3'b100
    } osc_phase_type;
endpackage

// [logic/osc_lfsr.sv]
/*
 * 16-bit test pattern shift register with a programmable tap mask.
 * Assumes the mask and controls are static between loads.
 */
`timescale 1ns/1ns
module osc_lfsr
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] taps,
    output logic             pattern
);
    logic [15:0] state;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= osc_pkg::LFSR_SEED;
        else if (load)
            state <= osc_pkg::LFSR_SEED;
        else if (run)
            state <= {state[14:0], state[15]}
                     ^ ({16{state[15]}} & taps);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pattern <= 1'b0;
        else
            pattern <= run & state[15];
    end
endmodule

// [logic/osc_power_monitor.sv]
/*
 * Power monitor: two threshold counters and a 48-bit start timer.
 * Assumes samples are signed and qualified by sample_valid.
 */
`timescale 1ns/1ns
module osc_power_monitor
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        collect,
    input  wire logic        above,
    input  wire logic [7:0]  threshold,
    input  wire logic        clear,
    input  wire logic        sample_valid,
    input  wire logic [7:0]  fifth_sample,
    input  wire logic [7:0]  sixth_sample,
    output logic      [11:0] fifth_count,
    output logic      [11:0] sixth_count,
    output logic      [47:0] start_timer
);
    function automatic logic hit(input logic [7:0] s,
                                 input logic [7:0] t,
                                 input logic a);
        hit = a ? ($signed(s) > $signed(t))
                : ($signed(s) < $signed(t));
    endfunction

    // Counters stick at full scale rather than wrap
    function automatic logic [11:0] bump(input logic [11:0] c);
        bump = (&c) ? c : c + 12'h001;
    endfunction

    logic active;
    assign active = collect & sample_valid;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fifth_count <= 12'h000;
        else if (clear)
            fifth_count <= 12'h000;
        else if (active && hit(fifth_sample, threshold, above))
            fifth_count <= bump(fifth_count);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sixth_count <= 12'h000;
        else if (clear)
            sixth_count <= 12'h000;
        else if (active && hit(sixth_sample, threshold, above))
            sixth_count <= bump(sixth_count);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            start_timer <= 48'h000000000000;
        else if (clear)
            start_timer <= 48'h000000000000;
        else if (collect)
            start_timer <= start_timer + 48'h000000000001;
    end
endmodule

// [logic/osc_regs.sv]
/*
 * Output stage control and status bank on APB, with saturation
 * interrupt, power monitor and test pattern generators.
 * Assumes one 25 MHz clock and stage saturation event pulses.
 */
// What this block does
// - Writing one to a self-clearing bit gives one pulse and the bit reads zero.
// - The status word shows the sixth count in 27:16 and the fifth in 11:0.
// - Each stage saturation sets its flag at bits 31,30,29,28,13,12.
// - A 48-bit start timer reads as a low word and sixteen upper bits.
// - Monitor control holds threshold, enable, direction and counter clear.
// - Saturation flags stay set until software writes one to them.
`timescale 1ns/1ns
module osc_regs
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  saturation_events,
    input  wire logic        power_sample_valid,
    input  wire logic [7:0]  fifth_power_sample,
    input  wire logic [7:0]  sixth_power_sample,
    output logic      [7:0]  sawtooth_lower_gain,
    output logic      [11:0] sawtooth_upper_gain,
    output logic      [21:0] frequency_word,
    output logic             fourth_modulator_word_load,
    output logic      [8:0]  fifth_gain,
    output logic      [8:0]  sixth_gain,
    output logic             alt_pattern_load_enable,
    output logic             complement_second_pair,
    output logic             pattern_clock_output_enable,
    output logic             ac_pair_off,
    output logic             bd_pair_off,
    output logic             sync_pattern,
    output logic             xor_pattern,
    output logic             pattern_clock,
    output logic             irq
);
    logic [9:0]  idx;
    logic        mapped;
    logic        wr;
    logic        rd_setup;
    logic [3:0]  spare;
    logic        xor_enable;
    logic        sync_enable;
    logic [5:0]  sat;
    logic [5:0]  sat_mask;
    logic [5:0]  sat_clear;
    logic [7:0]  threshold;
    logic        collect;
    logic        above;
    logic        count_clear;
    logic [11:0] fifth_count;
    logic [11:0] sixth_count;
    logic [47:0] start_timer;
    logic [15:0] xor_taps;
    logic [15:0] sync_taps;
    logic        pattern_reload;
    logic [31:0] next_prdata;

    function automatic logic [31:0] pack_sat(input logic [5:0] f);
        pack_sat = 32'h00000000;
        for (int i = 0; i < osc_pkg::SAT_N; i++)
            pack_sat[osc_pkg::SAT_POS[i]] = f[i];
    endfunction

    function automatic logic [5:0] unpack_sat(input logic [31:0] w);
        unpack_sat = 6'h00;
        for (int i = 0; i < osc_pkg::SAT_N; i++)
            unpack_sat[i] = w[osc_pkg::SAT_POS[i]];
    endfunction

    assign idx = paddr[11:2];

    // Register indices run unbroken from the gains word to the mask
    assign mapped = idx >= osc_pkg::IDX_GAINS && idx <= osc_pkg::IDX_MASK
                    && paddr[1:0] == 2'h0;

    // Zero wait state; read data is latched during setup
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;

    always_comb
    begin
        next_prdata = 32'h00000000;
        case (idx)
            osc_pkg::IDX_GAINS:
            begin
                next_prdata[osc_pkg::LOWER_LSB +: 8] =
                    sawtooth_lower_gain;
                next_prdata[osc_pkg::UPPER_LSB +: 12] =
                    sawtooth_upper_gain;
            end
            osc_pkg::IDX_LINK:
            begin
                next_prdata[osc_pkg::ALT_BIT] = alt_pattern_load_enable;
                next_prdata[osc_pkg::SPARE_LSB +: 4] = spare;
                next_prdata[osc_pkg::AC_OFF_BIT] = ac_pair_off;
                next_prdata[osc_pkg::BD_OFF_BIT] = bd_pair_off;
                next_prdata[osc_pkg::COMPL_BIT] = complement_second_pair;
                next_prdata[osc_pkg::PCLK_EN_BIT] =
                    pattern_clock_output_enable;
                next_prdata[osc_pkg::XOR_EN_BIT] = xor_enable;
                next_prdata[osc_pkg::SYNC_EN_BIT] = sync_enable;
            end
            osc_pkg::IDX_FREQ:
                next_prdata[osc_pkg::FREQ_W - 1:0] = frequency_word;
            osc_pkg::IDX_OGAIN:
            begin
                next_prdata[osc_pkg::SIXTH_LSB +: 9] = sixth_gain;
                next_prdata[osc_pkg::FIFTH_LSB +: 9] = fifth_gain;
            end
            osc_pkg::IDX_SAT:
            begin
                next_prdata = pack_sat(sat);
                next_prdata[osc_pkg::P6_LSB +: 12] = sixth_count;
                next_prdata[osc_pkg::P5_LSB +: 12] = fifth_count;
            end
            osc_pkg::IDX_PMCFG:
            begin
                next_prdata[osc_pkg::THR_LSB +: 8] = threshold;
                next_prdata[osc_pkg::COLLECT_BIT] = collect;
                next_prdata[osc_pkg::ABOVE_BIT] = above;
            end
            osc_pkg::IDX_TLOW:
                next_prdata = start_timer[31:0];
            osc_pkg::IDX_THIGH:
                next_prdata[15:0] = start_timer[47:32];
            osc_pkg::IDX_TAPS:
                next_prdata = {xor_taps, sync_taps};
            osc_pkg::IDX_MASK:
                next_prdata = pack_sat(sat_mask);
            default:
                next_prdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= mapped ? next_prdata : 32'h00000000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sawtooth_lower_gain <= osc_pkg::LOWER_RST;
            sawtooth_upper_gain <= osc_pkg::UPPER_RST;
        end
        else if (wr && idx == osc_pkg::IDX_GAINS)
        begin
            sawtooth_lower_gain <= pwdata[osc_pkg::LOWER_LSB +: 8];
            sawtooth_upper_gain <= pwdata[osc_pkg::UPPER_LSB +: 12];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alt_pattern_load_enable <= osc_pkg::LINK_RST[9];
            spare <= osc_pkg::LINK_RST[8:5];
            ac_pair_off <= osc_pkg::LINK_RST[4];
            bd_pair_off <= osc_pkg::LINK_RST[3];
            complement_second_pair <= osc_pkg::LINK_RST[2];
            pattern_clock_output_enable <= osc_pkg::LINK_RST[0];
            xor_enable <= osc_pkg::LINK_RST[0];
            sync_enable <= osc_pkg::LINK_RST[1];
        end
        else if (wr && idx == osc_pkg::IDX_LINK)
        begin
            alt_pattern_load_enable <= pwdata[osc_pkg::ALT_BIT];
            spare <= pwdata[osc_pkg::SPARE_LSB +: 4];
            ac_pair_off <= pwdata[osc_pkg::AC_OFF_BIT];
            bd_pair_off <= pwdata[osc_pkg::BD_OFF_BIT];
            complement_second_pair <= pwdata[osc_pkg::COMPL_BIT];
            pattern_clock_output_enable <= pwdata[osc_pkg::PCLK_EN_BIT];
            xor_enable <= pwdata[osc_pkg::XOR_EN_BIT];
            sync_enable <= pwdata[osc_pkg::SYNC_EN_BIT];
        end
    end

    // load strobe never stored, reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fourth_modulator_word_load <= 1'b0;
        else
            fourth_modulator_word_load <= wr
                && idx == osc_pkg::IDX_LINK
                && pwdata[osc_pkg::LOAD_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frequency_word <= 22'h000000;
        else if (wr && idx == osc_pkg::IDX_FREQ)
            frequency_word <= pwdata[osc_pkg::FREQ_W - 1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sixth_gain <= osc_pkg::SIXTH_RST;
            fifth_gain <= osc_pkg::FIFTH_RST;
        end
        else if (wr && idx == osc_pkg::IDX_OGAIN)
        begin
            sixth_gain <= pwdata[osc_pkg::SIXTH_LSB +: 9];
            fifth_gain <= pwdata[osc_pkg::FIFTH_LSB +: 9];
        end
    end

    assign sat_clear = (wr && idx == osc_pkg::IDX_SAT)
                       ? unpack_sat(pwdata) : 6'h00;

    // sticky, write one clears, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sat <= 6'h00;
        else
            sat <= (sat & ~sat_clear) | saturation_events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sat_mask <= 6'h00;
        else if (wr && idx == osc_pkg::IDX_MASK)
            sat_mask <= unpack_sat(pwdata);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(sat & sat_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            threshold <= 8'h00;
            collect <= 1'b0;
            above <= 1'b0;
        end
        else if (wr && idx == osc_pkg::IDX_PMCFG)
        begin
            threshold <= pwdata[osc_pkg::THR_LSB +: 8];
            collect <= pwdata[osc_pkg::COLLECT_BIT];
            above <= pwdata[osc_pkg::ABOVE_BIT];
        end
    end

    // counter clear is a single pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_clear <= 1'b0;
        else
            count_clear <= wr
                && idx == osc_pkg::IDX_PMCFG
                && pwdata[osc_pkg::CRST_BIT];
    end

    osc_power_monitor u_monitor
    (
        .clk          (pclk),
        .rst_n        (presetn),
        .collect      (collect),
        .above        (above),
        .threshold    (threshold),
        .clear        (count_clear),
        .sample_valid (power_sample_valid),
        .fifth_sample (fifth_power_sample),
        .sixth_sample (sixth_power_sample),
        .fifth_count  (fifth_count),
        .sixth_count  (sixth_count),
        .start_timer  (start_timer)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xor_taps <= osc_pkg::XOR_TAP_RST;
            sync_taps <= osc_pkg::SYNC_TAP_RST;
        end
        else if (wr && idx == osc_pkg::IDX_TAPS)
        begin
            xor_taps <= pwdata[osc_pkg::XOR_TAP_LSB +: 16];
            sync_taps <= pwdata[15:0];
        end
    end

    // Reseed only when allowed, so running patterns stay intact
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pattern_reload <= 1'b0;
        else
            pattern_reload <= wr && idx == osc_pkg::IDX_TAPS
                              && alt_pattern_load_enable;
    end

    osc_lfsr u_sync_lfsr
    (
        .clk     (pclk),
        .rst_n   (presetn),
        .run     (sync_enable),
        .load    (pattern_reload),
        .taps    (sync_taps),
        .pattern (sync_pattern)
    );

    osc_lfsr u_xor_lfsr
    (
        .clk     (pclk),
        .rst_n   (presetn),
        .run     (xor_enable),
        .load    (pattern_reload),
        .taps    (xor_taps),
        .pattern (xor_pattern)
    );

    // Pattern clock is half rate, low when disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pattern_clock <= 1'b0;
        else if (pattern_clock_output_enable)
            pattern_clock <= ~pattern_clock;
        else
            pattern_clock <= 1'b0;
    end
endmodule

// [dv/osc_regs_checker.sv]
/*
 * Port assertions for the output stage control register bank.
 * Assumes it is bound to osc_regs and sees only its ports.
 */
`timescale 1ns/1ns
module osc_regs_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [5:0]  saturation_events,
    input wire logic [21:0] frequency_word,
    input wire logic        fourth_modulator_word_load,
    input wire logic        pattern_clock,
    input wire logic        irq
);
    logic wr;
    assign wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    load_cause_a:
        assert property (fourth_modulator_word_load |->
            $past(wr && paddr == {osc_pkg::IDX_LINK, 2'b00} && pwdata[0]))
        else $error("load pulse without a load write");
    load_single_a:
        assert property (fourth_modulator_word_load |=>
            !fourth_modulator_word_load)
        else $error("load pulse longer than one cycle");
    clear_bits_zero_a:
        assert property (psel && !penable && !pwrite &&
            (paddr == {osc_pkg::IDX_PMCFG, 2'b00} ||
             paddr == {osc_pkg::IDX_LINK, 2'b00}) |=> !prdata[0])
        else $error("self clearing bit reads one");
    irq_cause_a:
        assert property ($rose(irq) |->
            $past(|saturation_events, 2) || $past(wr, 2))
        else $error("interrupt rose without event or write");
    irq_sticky_a:
        assert property (irq && !wr && !$past(wr) |=> irq)
        else $error("interrupt dropped without a write");
    err_decode_a:
        assert property (psel && penable |-> pslverr ==
            (paddr[1:0] != 2'b00 || paddr[11:2] < osc_pkg::IDX_GAINS
             || paddr[11:2] > osc_pkg::IDX_MASK))
        else $error("error response does not match address");
    freq_write_a:
        assert property (!$stable(frequency_word) |->
            $past(wr && paddr == {osc_pkg::IDX_FREQ, 2'b00}))
        else $error("frequency word changed without a write");
    pclk_toggle_a:
        assert property (pattern_clock |=> !pattern_clock)
        else $error("pattern clock stuck high");

    cover property (fourth_modulator_word_load);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule

bind osc_regs osc_regs_checker osc_regs_checker_inst
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pslverr, .saturation_events, .frequency_word,
    .fourth_modulator_word_load, .pattern_clock, .irq
);

// [dv/osc_regs_test.sv]
/*
 * Self-checking bench for the output stage control register bank.
 * Assumes osc_regs with its checker bound; bench is the APB master.
 */
`timescale 1ns/1ns
module osc_regs_test;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, last_err, power_sample_valid;
    logic [5:0]  saturation_events;
    logic [7:0]  fifth_power_sample, sixth_power_sample;
    logic [7:0]  sawtooth_lower_gain;
    logic [11:0] sawtooth_upper_gain;
    logic [21:0] frequency_word;
    logic [8:0]  fifth_gain, sixth_gain;
    logic        fourth_modulator_word_load, alt_pattern_load_enable;
    logic        complement_second_pair, pattern_clock_output_enable;
    logic        ac_pair_off, bd_pair_off, sync_pattern, xor_pattern;
    logic        pattern_clock, irq;
    int          miscompares, checks, cyc, last_cyc, loads;

    osc_regs osc_regs_inst
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .saturation_events,
        .power_sample_valid, .fifth_power_sample, .sixth_power_sample,
        .sawtooth_lower_gain, .sawtooth_upper_gain, .frequency_word,
        .fourth_modulator_word_load, .fifth_gain, .sixth_gain,
        .alt_pattern_load_enable, .complement_second_pair,
        .pattern_clock_output_enable, .ac_pair_off, .bd_pair_off,
        .sync_pattern, .xor_pattern, .pattern_clock, .irq
    );

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard; the run needs under 2000 cycles
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (fourth_modulator_word_load === 1'b1)
            loads <= loads + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Idle edge after each transfer
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        last_err = pslverr;
        last_cyc = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, {i, 2'b00}, d, q);
    endtask

    task automatic rdc(input logic [9:0] i, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, {i, 2'b00}, 32'h0, q);
        check32(q, e);
    endtask

    task automatic t_reset();
        check32({sawtooth_lower_gain, sawtooth_upper_gain, 3'h0, fifth_gain},
                32'h80800000);
        check32({sixth_gain, frequency_word, irq}, {9'h100, 23'h0});
        rdc(osc_pkg::IDX_GAINS, 32'h00800800);
        rdc(osc_pkg::IDX_LINK, 32'h00000002);
        rdc(osc_pkg::IDX_FREQ, 32'h0);
        rdc(osc_pkg::IDX_OGAIN, 32'h01000000);
        rdc(osc_pkg::IDX_SAT, 32'h0);
        rdc(osc_pkg::IDX_PMCFG, 32'h0);
        rdc(osc_pkg::IDX_TLOW, 32'h0);
        rdc(osc_pkg::IDX_THIGH, 32'h0);
        rdc(osc_pkg::IDX_TAPS, 32'h0500b400);
        rdc(osc_pkg::IDX_MASK, 32'h0);
    endtask

    task automatic t_rw();
        logic [9:0] ri[4] = '{osc_pkg::IDX_GAINS, osc_pkg::IDX_FREQ,
                              osc_pkg::IDX_OGAIN, osc_pkg::IDX_TAPS};
        logic [31:0] rm[4] = '{32'h00ff0fff, 32'h003fffff,
                               32'h01ff01ff, 32'hffffffff};
        for (int k = 0; k < 4; k++)
        begin
            wr(ri[k], 32'hffffffff);
            rdc(ri[k], rm[k]);
        end
        check32({sawtooth_lower_gain, sawtooth_upper_gain, 3'h0, fifth_gain},
                32'hfffff1ff);
    endtask

    task automatic t_load();
        int n;
        n = loads;
        wr(osc_pkg::IDX_FREQ, 32'h002aaaaa);
        wr(osc_pkg::IDX_LINK, 32'h00002a7f);
        repeat (2) @(posedge pclk);
        check32(32'(loads - n), 32'h1);
        check32({10'h0, frequency_word}, 32'h002aaaaa);
        rdc(osc_pkg::IDX_LINK, 32'h00002a7e);
        n = pattern_clock;
        @(posedge pclk);
        check32({31'h0, pattern_clock ^ n[0]}, 32'h1);
        check32({27'h0, alt_pattern_load_enable, complement_second_pair,
                 pattern_clock_output_enable, ac_pair_off, bd_pair_off},
                32'h1f);
    endtask

    task automatic t_sat();
        logic [31:0] e;
        e = 32'h0;
        for (int i = 0; i < 6; i++)
        begin
            saturation_events <= 6'h01 << i;
            @(posedge pclk);
            saturation_events <= 6'h00;
            e[osc_pkg::SAT_POS[i]] = 1'b1;
            rdc(osc_pkg::IDX_SAT, e);
        end
        check32({31'h0, irq}, 32'h0);
        wr(osc_pkg::IDX_MASK, 32'h80000000);
        rdc(osc_pkg::IDX_MASK, 32'h80000000);
        check32({31'h0, irq}, 32'h1);
        wr(osc_pkg::IDX_SAT, 32'h0);
        rdc(osc_pkg::IDX_SAT, e);
        wr(osc_pkg::IDX_SAT, 32'h80000000);
        @(posedge pclk);
        check32({31'h0, irq}, 32'h0);
        rdc(osc_pkg::IDX_SAT, 32'h70003000);
        wr(osc_pkg::IDX_SAT, e);
        rdc(osc_pkg::IDX_SAT, 32'h0);
    endtask

    task automatic t_err();
        logic [31:0] q;
        apb(1'b0, 12'h124, 32'h0, q);
        check32({q[31:1], last_err}, 32'h1);
        apb(1'b1, 12'h105, 32'h0, q);
        check32({31'h0, last_err}, 32'h1);
        apb(1'b0, 12'h105, 32'h0, q);
        check32({q[31:1], last_err}, 32'h1);
        apb(1'b0, 12'h104, 32'h0, q);
        check32({q[31:1], last_err}, 32'h002aaaaa);
    endtask

    task automatic t_mon(input logic above, input logic [11:0] n);
        logic [31:0] cfg;
        int c1, c2;
        cfg = {16'h0, 8'h10, 6'h0, above, 1'b0};
        wr(osc_pkg::IDX_PMCFG, cfg | 32'h1);
        wr(osc_pkg::IDX_PMCFG, cfg | 32'h4);
        c1 = last_cyc;
        fifth_power_sample <= 8'h20;
        sixth_power_sample <= 8'hf0;
        power_sample_valid <= 1'b1;
        repeat (n) @(posedge pclk);
        power_sample_valid <= 1'b0;
        wr(osc_pkg::IDX_PMCFG, cfg);
        c2 = last_cyc;
        rdc(osc_pkg::IDX_SAT, above ? {20'h0, n} : {4'h0, n, 16'h0});
        rdc(osc_pkg::IDX_TLOW, 32'(c2 - c1));
        rdc(osc_pkg::IDX_THIGH, 32'h0);
        rdc(osc_pkg::IDX_PMCFG, cfg);
        wr(osc_pkg::IDX_PMCFG, cfg | 32'h1);
        rdc(osc_pkg::IDX_TLOW, 32'h0);
        rdc(osc_pkg::IDX_SAT, 32'h0);
    endtask

    function automatic logic [15:0] step(logic [15:0] s, logic [15:0] t);
        return {s[14:0], s[15]} ^ (s[15] ? t : 16'h0);
    endfunction

    // Reseed lands one edge after the write, the pattern one edge later
    task automatic t_lfsr();
        logic [15:0] s, x;
        logic [31:0] cs, cx, ms, mx;
        s = 16'hffff;
        x = 16'hffff;
        wr(osc_pkg::IDX_TAPS, 32'h1234002d);
        @(posedge pclk);
        for (int j = 0; j < 32; j++)
        begin
            @(negedge pclk);
            cs[j] = sync_pattern;
            cx[j] = xor_pattern;
            ms[j] = s[15];
            mx[j] = x[15];
            s = step(s, 16'h002d);
            x = step(x, 16'h1234);
        end
        check32(cs, ms);
        check32(cx, mx);
    endtask

    initial
    begin
        {cyc, loads, miscompares, checks, last_cyc} = '0;
        {presetn, psel, penable, pwrite, power_sample_valid} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        saturation_events = 6'h0;
        fifth_power_sample = 8'h0;
        sixth_power_sample = 8'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_rw();
        t_load();
        t_sat();
        t_err();
        t_mon(1'b1, 12'd5);
        t_mon(1'b0, 12'd9);
        t_lfsr();
        stop_test();
    end
endmodule
